// >>> prc_pkg.sv
// Package: register map, field layout and fixed codes of the root port bank
package prc_pkg;

	// ----------------------------------------------------------------
	// Register offsets (byte addresses)
	// ----------------------------------------------------------------
	localparam logic [11:0] OFF_BRIDGE_VERSION_INFO = 12'h000;
	localparam logic [11:0] OFF_INTERNAL_BUS_INFO = 12'h004;
	localparam logic [11:0] OFF_PCIE_INTERFACE_INFO = 12'h010;
	localparam logic [11:0] OFF_CORE_IMPLEMENTATION_INFO = 12'h014;
	localparam logic [11:0] OFF_LINK_NEGOTIATED_STATUS = 12'h018;
	localparam logic [11:0] OFF_GENERAL_SETTINGS_LEGACY = 12'h080;
	localparam logic [11:0] OFF_CONFIG_ACCESS_NUMBER = 12'h140;
	localparam logic [11:0] OFF_LOCAL_INTERRUPT_MASK = 12'h180;
	localparam logic [11:0] OFF_LOCAL_INTERRUPT_STATUS = 12'h184;
	localparam logic [11:0] OFF_MSI_TARGET_ADDRESS = 12'h190;
	localparam logic [11:0] OFF_MSI_INTERRUPT_STATUS = 12'h194;
	localparam logic [11:0] OFF_POWER_COMMAND = 12'h198;
	localparam logic [11:0] OFF_PCIE_WINDOW0_XLAT_STATUS = 12'h1D8;
	localparam logic [11:0] OFF_PCIE_WINDOW1_XLAT_STATUS = 12'h1DC;
	localparam logic [11:0] OFF_AXI_SLAVE0_XLAT_STATUS = 12'h1E0;
	localparam logic [11:0] OFF_PCIE_WINDOW0_XLAT_TABLES = 12'h600;
	localparam logic [11:0] OFF_PCIE_WINDOW1_XLAT_TABLES = 12'h700;
	localparam logic [11:0] OFF_AXI_SLAVE0_XLAT_TABLES = 12'h800;
	localparam logic [11:0] OFF_ROOT_PORT_CONTROL = 12'h1F0;

	// Plain read/write configuration words, one offset each
	localparam int NUM_CFG = 16;
	localparam logic [11:0] CFG_OFFSETS [NUM_CFG] = '{
		12'h090, 12'h094, 12'h098, 12'h09C, 12'h0A0, 12'h0A4, 12'h0A8,
		12'h0AC, 12'h0B0, 12'h0C0, 12'h0C8, 12'h0D4, 12'h0D8, 12'h0DC,
		12'h0FC, 12'h100};
	localparam logic [11:0] OFF_EQ_PRESET_LANES23 = 12'h104;
	localparam logic [11:0] OFF_POWER_CONFIG_A = 12'h174;
	localparam logic [11:0] OFF_POWER_CONFIG_B = 12'h178;
	localparam logic [11:0] OFF_POWER_CONFIG_C = 12'h17C;

	// ----------------------------------------------------------------
	// Translation table windows: 256 bytes, 64 words each
	// ----------------------------------------------------------------
	localparam int XLAT_WIN_N = 3;
	localparam int XLAT_WORDS = 64;
	localparam int XLAT_AW = 6;

	// ----------------------------------------------------------------
	// Identification fields
	// ----------------------------------------------------------------
	localparam int VER_DMA_LSB = 24;
	localparam int VER_PRODUCT_LSB = 12;
	localparam int VER_VERSION_LSB = 0;
	// Product code value is arbitrary
	localparam logic [11:0] BRIDGE_PRODUCT_CODE = 12'h0A5;
	localparam logic [3:0] DMA_ENGINE_COUNT = 4'h2;
	localparam logic [3:0] DMA_ENGINE_MAX = 4'h8;
	localparam logic [11:0] CORE_VERSION = 12'h100;

	// ----------------------------------------------------------------
	// Size and capacity codes
	// ----------------------------------------------------------------
	localparam int FLD_RREQ_LSB = 28;
	localparam int FLD_PAYLOAD_LSB = 24;
	localparam int FLD_WRCAP_LSB = 20;
	localparam int FLD_RDCAP_LSB = 16;
	localparam int FLD_WIDTH_LSB = 12;
	localparam logic [3:0] SIZE_CODE_128B = 4'h0;
	localparam logic [3:0] SIZE_CODE_4096B = 4'h5;
	localparam logic [3:0] BUS_RREQ_CODE = 4'h5;
	localparam logic [3:0] BUS_PAYLOAD_CODE = 4'h5;
	localparam logic [3:0] PENDING_CODE_256 = 4'h8;
	localparam logic [3:0] WIDTH_CODE_256 = 4'h5;
	localparam logic [11:0] BUS_VERSION = 12'h100;
	localparam logic [3:0] IF_RREQ_CODE = 4'h5;
	localparam logic [3:0] IF_PAYLOAD_CODE = 4'h5;
	localparam logic [3:0] INBOUND_READ_CODE = 4'h7;
	localparam logic [3:0] OUTBOUND_READ_CODE = 4'h7;
	localparam logic [3:0] INTERFACE_TARGET_NUMBER = 4'h0;
	localparam logic [11:0] PCIE_CORE_VERSION = 12'h100;

	// ----------------------------------------------------------------
	// Reset values
	// ----------------------------------------------------------------
	localparam logic [31:0] RST_WORD = 32'h0000_0000;
	localparam logic [31:0] RST_CREDIT_A = 32'hFFFF_FFFF;
	localparam logic [31:0] RST_CREDIT_B = 32'h00FF_FFFF;
	localparam logic [31:0] RST_CORE_IMPL = 32'h1311_0701;

endpackage : prc_pkg

// >>> prc_regs.sv
// Root port configuration register bank with APB slave port
// Notes on behaviour
// - Interrupt mask, status and power command stay writable after release.
// - Bridge version bits 27:24 give DMA engine count, zero to eight.
// - Bridge version bits 23:12 hold a fixed read-only product code.
// - Bridge version bits 11:0 give core version as three hex digits.
// - Internal bus bits 31:28 give max read request size code.
// - Internal bus bits 27:24 give max payload size code.
// - Internal bus write and read pending capacity codes are 8, 256 each.
// - Internal bus bits 15:12 give width code 5 for 256 bits.
// - Internal bus bits 11:0 give the bus version digits.
// - Interface bits 19:16 give outbound read capacity code.
// - Interface bits 15:12 read as zero, the interface target number.
// - Interface bits 11:0 give the controller core version.
// - Three writable translation table windows at 0x600, 0x700, 0x800.
//
// The implementer's own choice: the APB register port.
module prc_regs
	import prc_pkg::*;
(
	input wire logic pclk,
	input wire logic presetn,
	input wire logic psel,
	input wire logic penable,
	input wire logic pwrite,
	input wire logic [11:0] paddr,
	input wire logic [31:0] pwdata,
	input wire logic [3:0] pstrb,
	output logic [31:0] prdata,
	output logic pready,
	output logic pslverr,
	input wire logic [31:0] local_event,
	input wire logic [31:0] msi_event,
	output logic irq,
	output logic root_port_reset_release,
	output logic [31:0] power_command
);

	// ----------------------------------------------------------------
	// Bus decode
	// ----------------------------------------------------------------
	typedef enum logic [0:0] {
		PRC_IDLE = 1'b0,
		PRC_DONE = 1'b1
	} prc_state_t;

	prc_state_t state_q;
	logic [31:0] mask_q;
	logic [31:0] lstat_q;
	logic [31:0] mstat_q;
	logic [31:0] pcmd_q;
	logic rel_q;
	logic [31:0] cfg_q [NUM_CFG];
	logic [31:0] eq23_q;
	logic [31:0] pm_q [3];
	logic [31:0] xlat_q [XLAT_WIN_N][XLAT_WORDS];
	logic [31:0] rdata_q;
	logic err_q;
	logic irq_q;

	function automatic logic [31:0] strb_merge(
		input logic [31:0] old,
		input logic [31:0] nw,
		input logic [3:0] be
	);
		logic [31:0] r;
		r = old;
		for (int i = 0; i < 4; i++) begin
			if (be[i]) begin
				r[8*i +: 8] = nw[8*i +: 8];
			end
		end
		return r;
	endfunction : strb_merge

	wire access = psel && penable && (state_q == PRC_IDLE);
	wire wr = psel && penable && pwrite && (state_q == PRC_DONE);
	wire [31:0] wmask = {{8{pstrb[3]}}, {8{pstrb[2]}},
		{8{pstrb[1]}}, {8{pstrb[0]}}};
	wire xhit = (paddr[11:8] >= 4'h6) && (paddr[11:8] <= 4'h8);
	wire [XLAT_AW-1:0] xidx = paddr[7:2];
	wire [1:0] pmi = 2'(paddr[3:2] - 2'd1);
	wire pm_hit = (paddr >= OFF_POWER_CONFIG_A) &&
		(paddr <= OFF_POWER_CONFIG_C) && (paddr[1:0] == 2'b00);
	wire hit_mask = (paddr == OFF_LOCAL_INTERRUPT_MASK);
	wire hit_lstat = (paddr == OFF_LOCAL_INTERRUPT_STATUS);
	wire hit_mstat = (paddr == OFF_MSI_INTERRUPT_STATUS);
	wire hit_pcmd = (paddr == OFF_POWER_COMMAND);
	wire hit_ctl = (paddr == OFF_ROOT_PORT_CONTROL);
	wire hit_eq = (paddr == OFF_EQ_PRESET_LANES23);
	wire [3:0] xw4 = paddr[11:8] - 4'h6;
	wire [1:0] xsel = xw4[1:0];

	// ----------------------------------------------------------------
	// Fixed information words
	// ----------------------------------------------------------------
	wire [31:0] ver_word = {4'h0, DMA_ENGINE_COUNT, BRIDGE_PRODUCT_CODE,
		CORE_VERSION};
	wire [31:0] bus_word = {BUS_RREQ_CODE, BUS_PAYLOAD_CODE,
		PENDING_CODE_256, PENDING_CODE_256, WIDTH_CODE_256,
		BUS_VERSION};
	wire [31:0] if_word = {IF_RREQ_CODE, IF_PAYLOAD_CODE,
		INBOUND_READ_CODE, OUTBOUND_READ_CODE, INTERFACE_TARGET_NUMBER,
		PCIE_CORE_VERSION};

	// ----------------------------------------------------------------
	// Read mux
	// ----------------------------------------------------------------
	logic [31:0] rd_d;
	logic hit_d;
	always_comb begin
		rd_d = RST_WORD;
		hit_d = 1'b1;
		if (xhit) begin
			rd_d = xlat_q[xsel][xidx];
		end else if (pm_hit) begin
			rd_d = pm_q[pmi];
		end else if (hit_eq) begin
			rd_d = eq23_q;
		end else begin
			unique case (paddr)
				OFF_BRIDGE_VERSION_INFO: rd_d = ver_word;
				OFF_INTERNAL_BUS_INFO: rd_d = bus_word;
				OFF_PCIE_INTERFACE_INFO: rd_d = if_word;
				OFF_CORE_IMPLEMENTATION_INFO: rd_d = RST_CORE_IMPL;
				OFF_LINK_NEGOTIATED_STATUS: rd_d = RST_WORD;
				OFF_GENERAL_SETTINGS_LEGACY: rd_d = RST_WORD;
				OFF_CONFIG_ACCESS_NUMBER: rd_d = RST_WORD;
				OFF_LOCAL_INTERRUPT_MASK: rd_d = mask_q;
				OFF_LOCAL_INTERRUPT_STATUS: rd_d = lstat_q;
				OFF_MSI_TARGET_ADDRESS: rd_d = RST_WORD;
				OFF_MSI_INTERRUPT_STATUS: rd_d = mstat_q;
				OFF_POWER_COMMAND: rd_d = pcmd_q;
				OFF_PCIE_WINDOW0_XLAT_STATUS: rd_d = RST_WORD;
				OFF_PCIE_WINDOW1_XLAT_STATUS: rd_d = RST_WORD;
				OFF_AXI_SLAVE0_XLAT_STATUS: rd_d = RST_WORD;
				OFF_ROOT_PORT_CONTROL: rd_d = {31'h0, rel_q};
				default: begin
					hit_d = 1'b0;
					for (int i = 0; i < NUM_CFG; i++) begin
						if (paddr == CFG_OFFSETS[i]) begin
							rd_d = cfg_q[i];
							hit_d = 1'b1;
						end
					end
				end
			endcase
		end
	end

	// ----------------------------------------------------------------
	// APB handshake: one wait state, answer in the second access cycle
	// ----------------------------------------------------------------
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			state_q <= PRC_IDLE;
			rdata_q <= RST_WORD;
			err_q <= 1'b0;
		end else if (access) begin
			state_q <= PRC_DONE;
			rdata_q <= pwrite ? RST_WORD : rd_d;
			err_q <= ~hit_d;
		end else begin
			state_q <= PRC_IDLE;
			err_q <= 1'b0;
		end
	end

	assign prdata = rdata_q;
	assign pready = (state_q == PRC_DONE);
	assign pslverr = err_q;

	// ----------------------------------------------------------------
	// Configuration words and translation tables
	// ----------------------------------------------------------------
	genvar g;
	generate
		for (g = 0; g < NUM_CFG; g++) begin : g_cfg
			always_ff @(posedge pclk or negedge presetn) begin
				if (!presetn) begin
					cfg_q[g] <= (g == 0) ? RST_CREDIT_A :
						(g == 1) ? RST_CREDIT_B : RST_WORD;
				end else if (wr && paddr == CFG_OFFSETS[g]) begin
					cfg_q[g] <= strb_merge(cfg_q[g], pwdata, pstrb);
				end
			end
		end
		for (g = 0; g < 3; g++) begin : g_pm
			always_ff @(posedge pclk or negedge presetn) begin
				if (!presetn) begin
					pm_q[g] <= RST_WORD;
				end else if (wr && pm_hit && pmi == 2'(g)) begin
					pm_q[g] <= strb_merge(pm_q[g], pwdata, pstrb);
				end
			end
		end
	endgenerate

	always_ff @(posedge pclk) begin
		if (wr && xhit) begin
			xlat_q[xsel][xidx] <= strb_merge(xlat_q[xsel][xidx], pwdata,
				pstrb);
		end
	end

	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			eq23_q <= RST_WORD;
			rel_q <= 1'b0;
		end else begin
			if (wr && hit_eq) begin
				eq23_q <= strb_merge(eq23_q, pwdata, pstrb);
			end
			if (wr && hit_ctl && pstrb[0]) begin
				rel_q <= pwdata[0];
			end
		end
	end

	// ----------------------------------------------------------------
	// Interrupt mask, status and power command
	// ----------------------------------------------------------------
	wire [31:0] lclr = (wr && hit_lstat) ? (pwdata & wmask) : 32'h0;
	wire [31:0] mclr = (wr && hit_mstat) ? (pwdata & wmask) : 32'h0;
	wire [31:0] lstat_d = (lstat_q & ~lclr) | local_event;
	wire [31:0] mstat_d = (mstat_q & ~mclr) | msi_event;
	wire irq_d = |(lstat_d & mask_q) | (|mstat_d);

	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			mask_q <= RST_WORD;
			lstat_q <= RST_WORD;
			mstat_q <= RST_WORD;
			pcmd_q <= RST_WORD;
			irq_q <= 1'b0;
		end else begin
			if (wr && hit_mask) begin
				mask_q <= strb_merge(mask_q, pwdata, pstrb);
			end
			if (wr && hit_pcmd) begin
				pcmd_q <= strb_merge(pcmd_q, pwdata, pstrb);
			end
			lstat_q <= lstat_d;
			mstat_q <= mstat_d;
			irq_q <= irq_d;
		end
	end

	assign irq = irq_q;
	assign root_port_reset_release = rel_q;
	assign power_command = pcmd_q;

	// ----------------------------------------------------------------
	// Checks
	// ----------------------------------------------------------------
	sequence s_read_ver;
		psel && penable && !pwrite && state_q == PRC_IDLE &&
			paddr == OFF_BRIDGE_VERSION_INFO;
	endsequence

	sequence s_read_bus;
		access && !pwrite && paddr == OFF_INTERNAL_BUS_INFO;
	endsequence

	sequence s_read_if;
		access && !pwrite && paddr == OFF_PCIE_INTERFACE_INFO;
	endsequence

	AST_DMA_RANGE: assert property (
		@(posedge pclk) disable iff (!presetn)
		s_read_ver |=> pready && prdata[27:24] <= DMA_ENGINE_MAX)
		else $error("dma count out of range");
	AST_PRODUCT: assert property (
		@(posedge pclk) disable iff (!presetn)
		s_read_ver |=> prdata[23:12] == BRIDGE_PRODUCT_CODE)
		else $error("product code wrong");
	AST_VERSION: assert property (
		@(posedge pclk) disable iff (!presetn)
		s_read_ver |=> prdata[11:0] == CORE_VERSION)
		else $error("core version wrong");
	AST_BUS_WORD: assert property (
		@(posedge pclk) disable iff (!presetn)
		s_read_bus |=> prdata[31:12] == 20'h55885)
		else $error("internal bus word wrong");
	AST_BUS_VERSION: assert property (
		@(posedge pclk) disable iff (!presetn)
		s_read_bus |=> prdata[11:0] == BUS_VERSION)
		else $error("internal bus version wrong");
	AST_IF_TARGET: assert property (
		@(posedge pclk) disable iff (!presetn)
		s_read_if |=> prdata[15:12] == 4'h0 && prdata[23:16] == 8'h77)
		else $error("interface word wrong");
	AST_IF_SIZES: assert property (
		@(posedge pclk) disable iff (!presetn)
		s_read_if |=> prdata[31:24] == {IF_RREQ_CODE, IF_PAYLOAD_CODE})
		else $error("interface size codes wrong");
	AST_IF_VERSION: assert property (
		@(posedge pclk) disable iff (!presetn)
		s_read_if |=> prdata[11:0] == PCIE_CORE_VERSION)
		else $error("interface core version wrong");
	AST_W1C: assert property (
		@(posedge pclk) disable iff (!presetn)
		(wr && hit_lstat && pstrb == 4'hF && pwdata[0] && !local_event[0])
		|=> !lstat_q[0])
		else $error("status bit not cleared");
	AST_W0_KEEP: assert property (
		@(posedge pclk) disable iff (!presetn)
		(lstat_q[0] && !(wr && hit_lstat && pwdata[0] && pstrb[0]))
		|=> lstat_q[0])
		else $error("status bit lost");
	AST_SET_WINS: assert property (
		@(posedge pclk) disable iff (!presetn)
		local_event[0] |=> lstat_q[0])
		else $error("status bit not set by event");
	AST_MASK_LIVE: assert property (
		@(posedge pclk) disable iff (!presetn)
		(wr && hit_mask && pstrb == 4'hF && rel_q) |=> mask_q == $past(pwdata))
		else $error("mask not written after release");
	AST_IRQ: assert property (
		@(posedge pclk) disable iff (!presetn)
		(|(lstat_q & mask_q)) |-> ##[0:1] irq)
		else $error("irq missing");
	AST_MSI_IRQ: assert property (
		@(posedge pclk) disable iff (!presetn)
		(|mstat_q) |-> irq)
		else $error("irq missing for msi status");
	AST_XLAT_WRITE: assert property (
		@(posedge pclk) disable iff (!presetn)
		(wr && xhit && pstrb == 4'hF) |=>
		xlat_q[$past(xsel)][$past(xidx)] == $past(pwdata))
		else $error("translation word not written");
	AST_READY: assert property (
		@(posedge pclk) disable iff (!presetn)
		access |=> pready ##1 !pready)
		else $error("ready timing wrong");
	AST_ERR_WITH_READY: assert property (
		@(posedge pclk) disable iff (!presetn)
		pslverr |-> pready)
		else $error("error without ready");
	AST_WRITE_DATA_ZERO: assert property (
		@(posedge pclk) disable iff (!presetn)
		(access && pwrite) |=> prdata == RST_WORD)
		else $error("read data not zero on write");

endmodule : prc_regs

// >>> test_prc_regs.sv
// Self-checking testbench for the root port configuration register bank
module test_prc_regs
	import prc_pkg::*;
;
	timeunit 1ns;
	timeprecision 1ps;

	// ----------------------------------------------------------------
	// Signals, clock and timeout
	// ----------------------------------------------------------------
	logic pclk, presetn, psel, penable, pwrite;
	logic [11:0] paddr;
	logic [31:0] pwdata, prdata, local_event, msi_event, power_command;
	logic [3:0] pstrb;
	logic pready, pslverr, irq, root_port_reset_release;
	int n_errors = 0;
	int comparisons = 0;
	int cycles = 0;

	prc_regs u_dut (.pclk(pclk), .presetn(presetn), .psel(psel),
		.penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
		.pstrb(pstrb), .prdata(prdata), .pready(pready), .pslverr(pslverr),
		.local_event(local_event), .msi_event(msi_event), .irq(irq),
		.root_port_reset_release(root_port_reset_release),
		.power_command(power_command));

	initial begin
		pclk = 1'b0;
		forever #20 pclk = ~pclk;
	end

	always @(posedge pclk) begin
		cycles++;
		if (cycles >= 20000) begin
			n_errors++;
			report_and_stop();
		end
	end

	// ----------------------------------------------------------------
	// Shared tasks
	// ----------------------------------------------------------------
	task automatic report_and_stop();
		if (n_errors == 0 && comparisons > 0) begin
			$display("STATUS OK");
		end else begin
			$display("STATUS NOT OK");
		end
		$finish;
	endtask : report_and_stop

	task automatic chk(input string nm, input logic [31:0] exp,
		input logic [31:0] got);
		comparisons++;
		if (got !== exp) begin
			$display("unexpected %s expected %h seen %h", nm, exp, got);
			n_errors++;
		end
	endtask : chk

	task automatic apb(input logic wr, input logic [11:0] a,
		input logic [31:0] d, input logic [3:0] s,
		output logic [31:0] rd, output logic err);
		int n;
		@(posedge pclk);
		psel <= 1'b1;
		penable <= 1'b0;
		pwrite <= wr;
		paddr <= a;
		pwdata <= d;
		pstrb <= s;
		@(posedge pclk);
		penable <= 1'b1;
		n = 0;
		do begin
			@(posedge pclk);
			n++;
		end while (pready !== 1'b1);
		rd = prdata;
		err = pslverr;
		psel <= 1'b0;
		penable <= 1'b0;
		chk("pready wait cycles", 32'h2, 32'(n));
	endtask : apb

	task automatic wr32(input logic [11:0] a, input logic [31:0] d,
		input logic [3:0] s, input logic exp_err);
		logic [31:0] r;
		logic e;
		apb(1'b1, a, d, s, r, e);
		chk("pslverr on write", {31'h0, exp_err}, {31'h0, e});
	endtask : wr32

	task automatic rd_chk(input string nm, input logic [11:0] a,
		input logic [31:0] exp, input logic exp_err);
		logic [31:0] r;
		logic e;
		apb(1'b0, a, 32'h0, 4'h0, r, e);
		chk(nm, exp, r);
		chk("pslverr on read", {31'h0, exp_err}, {31'h0, e});
	endtask : rd_chk

	task automatic pulse_event(input logic [31:0] lo, input logic [31:0] ms);
		@(posedge pclk);
		local_event <= lo;
		msi_event <= ms;
		@(posedge pclk);
		local_event <= 32'h0;
		msi_event <= 32'h0;
		repeat (2) @(posedge pclk);
	endtask : pulse_event

	// ----------------------------------------------------------------
	// Scenarios
	// ----------------------------------------------------------------
	task automatic t_ident();
		logic [31:0] ver;
		ver = {4'h0, DMA_ENGINE_COUNT, BRIDGE_PRODUCT_CODE, CORE_VERSION};
		rd_chk("bridge_version_info", OFF_BRIDGE_VERSION_INFO, ver, 1'b0);
		wr32(OFF_BRIDGE_VERSION_INFO, 32'hFFFF_FFFF, 4'hF, 1'b0);
		rd_chk("bridge_version_info", OFF_BRIDGE_VERSION_INFO, ver, 1'b0);
		rd_chk("internal_bus_info", OFF_INTERNAL_BUS_INFO, {BUS_RREQ_CODE,
			BUS_PAYLOAD_CODE, 4'h8, 4'h8, 4'h5, BUS_VERSION}, 1'b0);
		wr32(OFF_PCIE_INTERFACE_INFO, 32'h0000_F000, 4'hF, 1'b0);
		rd_chk("pcie_interface_info", OFF_PCIE_INTERFACE_INFO, {IF_RREQ_CODE,
			IF_PAYLOAD_CODE, INBOUND_READ_CODE, OUTBOUND_READ_CODE, 4'h0,
			PCIE_CORE_VERSION}, 1'b0);
	endtask : t_ident

	task automatic t_xlat();
		logic [11:0] b;
		for (int w = 0; w < 3; w++) begin
			b = 12'h600 + 12'(w * 256);
			wr32(b, 32'hA5A5_0000 | 32'(w), 4'hF, 1'b0);
			wr32(b + 12'h0FC, 32'h3C3C_0F00 | 32'(w), 4'hF, 1'b0);
			wr32(b, 32'hFFFF_FFFF, 4'h2, 1'b0);
		end
		for (int w = 0; w < 3; w++) begin
			b = 12'h600 + 12'(w * 256);
			rd_chk("xlat first word", b, 32'hA5A5_FF00 | 32'(w), 1'b0);
			rd_chk("xlat last word", b + 12'h0FC, 32'h3C3C_0F00 | 32'(w),
				1'b0);
		end
		for (int i = 0; i < NUM_CFG; i++) begin
			wr32(CFG_OFFSETS[i], {20'h5A5A5, CFG_OFFSETS[i]}, 4'hF, 1'b0);
		end
		for (int i = 0; i < NUM_CFG; i++) begin
			rd_chk("config word", CFG_OFFSETS[i], {20'h5A5A5, CFG_OFFSETS[i]},
				1'b0);
		end
	endtask : t_xlat

	task automatic t_unmapped();
		rd_chk("unmapped read", 12'h008, 32'h0, 1'b1);
		wr32(12'h1E4, 32'hFFFF_FFFF, 4'hF, 1'b1);
		rd_chk("unmapped read", 12'h1E4, 32'h0, 1'b1);
	endtask : t_unmapped

	task automatic t_irq();
		wr32(OFF_ROOT_PORT_CONTROL, 32'h1, 4'hF, 1'b0);
		repeat (2) @(posedge pclk);
		chk("root_port_reset_release", 32'h1, {31'h0, root_port_reset_release});
		wr32(OFF_POWER_COMMAND, 32'h0000_0C3A, 4'hF, 1'b0);
		repeat (2) @(posedge pclk);
		chk("power_command", 32'h0000_0C3A, power_command);
		pulse_event(32'h0000_0009, 32'h0);
		rd_chk("local status", OFF_LOCAL_INTERRUPT_STATUS, 32'h9, 1'b0);
		chk("irq while masked", 32'h0, {31'h0, irq});
		wr32(OFF_LOCAL_INTERRUPT_MASK, 32'h8, 4'hF, 1'b0);
		repeat (2) @(posedge pclk);
		chk("irq unmasked", 32'h1, {31'h0, irq});
		wr32(OFF_LOCAL_INTERRUPT_STATUS, 32'hFFFF_FFF7, 4'hF, 1'b0);
		rd_chk("local status", OFF_LOCAL_INTERRUPT_STATUS, 32'h8, 1'b0);
		wr32(OFF_LOCAL_INTERRUPT_STATUS, 32'h8, 4'hF, 1'b0);
		rd_chk("local status", OFF_LOCAL_INTERRUPT_STATUS, 32'h0, 1'b0);
		chk("irq after clear", 32'h0, {31'h0, irq});
		pulse_event(32'h0, 32'h8000_0000);
		rd_chk("msi status", OFF_MSI_INTERRUPT_STATUS, 32'h8000_0000, 1'b0);
		chk("irq from msi", 32'h1, {31'h0, irq});
		wr32(OFF_MSI_INTERRUPT_STATUS, 32'h7FFF_FFFF, 4'hF, 1'b0);
		rd_chk("msi status", OFF_MSI_INTERRUPT_STATUS, 32'h8000_0000, 1'b0);
		wr32(OFF_MSI_INTERRUPT_STATUS, 32'h8000_0000, 4'hF, 1'b0);
		rd_chk("msi status", OFF_MSI_INTERRUPT_STATUS, 32'h0, 1'b0);
		chk("irq after msi clear", 32'h0, {31'h0, irq});
	endtask : t_irq

	// ----------------------------------------------------------------
	// Main sequence
	// ----------------------------------------------------------------
	initial begin
		presetn = 1'b0;
		psel = 1'b0;
		penable = 1'b0;
		pwrite = 1'b0;
		paddr = 12'h000;
		pwdata = 32'h0;
		pstrb = 4'hF;
		local_event = 32'h0;
		msi_event = 32'h0;
		repeat (6) @(posedge pclk);
		presetn <= 1'b1;
		t_ident();
		t_xlat();
		t_unmapped();
		t_irq();
		report_and_stop();
	end

endmodule : test_prc_regs
